// ---- rtl/rmp_regs.svh ----
`ifndef RMP_REGS_SVH
`define RMP_REGS_SVH

`define RMP_GENCTRL_OFS 12'h184
`define RMP_TUNING_OFS 12'h18c
`define RMP_PART_OFS 12'h194
`define RMP_STS_OFS 12'h1a8
`define RMP_MSK_OFS 12'h1ac
`define RMP_SEV_OFS 12'h1b0

`define RMP_LOCK_BIT 15
`define RMP_HPA_MSB 7
`define RMP_HPA_LSB 4
`define RMP_GPA_MSB 3
`define RMP_GPA_LSB 0
`define RMP_HPA_BASE 7'h24
`define RMP_GPA_BASE 7'h28
`define RMP_GPA_MAX_CODE 4'h8
`define RMP_GENCTRL_RST 32'h000000a8

`define RMP_THR_MSB 18
`define RMP_THR_LSB 12
`define RMP_SRC_BIT 11
`define RMP_RATE_MSB 10
`define RMP_RATE_LSB 7
`define RMP_IGN_UBIT_BIT 3
`define RMP_EVICT_NL_BIT 2
`define RMP_KEEP_LEAF_BIT 1
`define RMP_TUNING_RST 32'h00004380
`define RMP_REQ_STEP 12'h010
`define RMP_CYC_STEP 12'h100

`define RMP_PART_EN_BIT 0
`define RMP_PART_MASK 32'h1f807e01
`define RMP_PART_RST 32'h00000000

`define RMP_FAULT_BIT 31
`define RMP_MISC_BIT 7
`define RMP_ERR_MASK 32'h800001ff
`define RMP_MSK_RST 32'h80000000
`define RMP_SEV_RST 32'h000001bf

`endif

// ---- rtl/rmp_pkg.sv ----
package rmp_pkg;
	typedef enum logic [1:0]
	{
		RMP_AT_UNTRANSLATED,
		RMP_AT_XLATE_REQ,
		RMP_AT_TRANSLATED,
		RMP_AT_RESERVED
	} rmp_at_t;

	typedef logic [8:0] rmp_err_vec_t;
endpackage

// ---- rtl/rmp_lru_ager.sv ----
`include "rmp_regs.svh"

module rmp_lru_ager import rmp_pkg::*;
#(
	parameter int CNT_W = 12
)
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic source_cycles_i,
	input wire logic [3:0] rate_i,
	input wire logic req_i,
	output logic degrade_o
);
	if (CNT_W < 12)
	begin
		$error("rmp_lru_ager: CNT_W too small for 256*15");
	end

	logic [CNT_W-1:0] cnt_ff;
	logic [CNT_W-1:0] nxt_cnt;
	logic degrade_ff;
	logic nxt_degrade;
	logic [CNT_W-1:0] limit;
	logic tick;

	always_comb
	begin
		// Cycle mode ticks every clock, request mode on each request
		tick = source_cycles_i ? 1'b1 : req_i;
		limit = source_cycles_i ? CNT_W'(`RMP_CYC_STEP * rate_i)
			: CNT_W'(`RMP_REQ_STEP * rate_i);
		nxt_cnt = cnt_ff;
		nxt_degrade = 1'b0;
		if (rate_i == 4'h0)
			nxt_cnt = '0;
		else if (tick)
		begin
			if (cnt_ff + CNT_W'(1) >= limit)
			begin
				nxt_cnt = '0;
				nxt_degrade = 1'b1;
			end
			else
				nxt_cnt = cnt_ff + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			cnt_ff <= '0;
			degrade_ff <= 1'b0;
		end
		else
		begin
			cnt_ff <= nxt_cnt;
			degrade_ff <= nxt_degrade;
		end
	end

	assign degrade_o = degrade_ff;
endmodule

// ---- rtl/rmp_limits_errors.sv ----
`include "rmp_regs.svh"

module rmp_limits_errors import rmp_pkg::*;
#(
	parameter int ADDR_W = 64
)
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic cfg_valid_i,
	input wire logic cfg_write_i,
	input wire logic [11:0] cfg_addr_i,
	input wire logic [3:0] cfg_be_i,
	input wire logic [31:0] cfg_wdata_i,
	input wire logic cfg_trusted_i,
	output logic [31:0] cfg_rdata_o,
	output logic cfg_ack_o,
	output logic base_enable_writable_o,
	input wire logic translation_on_i,
	input wire logic req_valid_i,
	input wire logic [ADDR_W-1:0] req_addr_i,
	input wire logic [1:0] req_at_i,
	input wire logic req_passthru_i,
	input wire logic req_walk_i,
	input wire logic req_noniso_i,
	input wire logic illegal_intr_region_i,
	output logic req_abort_o,
	output logic req_ur_o,
	input wire logic [8:0] err_event_i,
	input wire logic remap_fault_i,
	output logic err_fatal_o,
	output logic err_nonfatal_o,
	input wire logic [6:0] free_entries_i,
	input wire logic prefetch_req_i,
	output logic prefetch_retry_o,
	output logic lru_degrade_o,
	input wire logic evict_valid_i,
	input wire logic [1:0] evict_at_i,
	input wire logic evict_leaf_i,
	input wire logic evict_ubit_i,
	output logic early_evict_o,
	output logic leaf_ubit_used_o,
	output logic part_en_o,
	output logic [1:0] range_sel_bridge_o,
	output logic [1:0] range_sel_upper24_o,
	output logic [1:0] range_sel_upper23_o,
	output logic [1:0] range_select_mgmt_engine_o,
	output logic [1:0] range_select_copy_engine_o,
	output logic [1:0] range_sel_intr_o
);
	if (ADDR_W < 48)
	begin
		$error("rmp_limits_errors: ADDR_W must cover 48 bits");
	end

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be, input logic [31:0] field);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & field;
		return (old & ~m) | (wd & m);
	endfunction

	function automatic logic over_limit(input logic [ADDR_W-1:0] a, input logic [6:0] w);
		return (a >> w) != '0;
	endfunction

	// Mask and severity hold L1/L2 parity in opposite places to status
	function automatic rmp_err_vec_t sts_to_ctl(input rmp_err_vec_t s);
		rmp_err_vec_t r;
		r = s;
		r[1] = s[2];
		r[2] = s[1];
		return r;
	endfunction

	// Reset release
	logic rst_s1_ff;
	logic rst_n;

	always_ff @(posedge clk_i or negedge resetn_i)
	begin
		if (!resetn_i)
		begin
			rst_s1_ff <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_s1_ff <= 1'b1;
			rst_n <= rst_s1_ff;
		end
	end

	// Register file
	logic [31:0] genctrl_ff;
	logic [31:0] nxt_genctrl;
	logic lock_done_ff;
	logic nxt_lock_done;
	logic [31:0] tuning_ff;
	logic [31:0] nxt_tuning;
	logic [31:0] part_ff;
	logic [31:0] nxt_part;
	logic [31:0] msk_ff;
	logic [31:0] nxt_msk;
	logic [31:0] sev_ff;
	logic [31:0] nxt_sev;
	logic [31:0] sts_ff;
	logic [31:0] nxt_sts;
	logic [31:0] rdata_ff;
	logic [31:0] nxt_rdata;
	logic ack_ff;
	logic nxt_ack;
	logic bew_ff;
	logic nxt_bew;
	logic wr;
	logic lb_ok;
	logic [31:0] lb_fields;
	logic misc_evt;
	logic [31:0] set_vec;

	always_comb
	begin
		wr = cfg_valid_i && cfg_write_i;
		// Lockable fields follow the lock and the trusted channel
		lb_ok = !genctrl_ff[`RMP_LOCK_BIT] || cfg_trusted_i;
		nxt_genctrl = genctrl_ff;
		nxt_lock_done = lock_done_ff;
		nxt_tuning = tuning_ff;
		nxt_part = part_ff;
		nxt_msk = msk_ff;
		nxt_sev = sev_ff;
		lb_fields = 32'h0000_00ff;
		if (wr && cfg_addr_i == `RMP_GENCTRL_OFS)
		begin
			if (lb_ok)
				nxt_genctrl = merge(nxt_genctrl, cfg_wdata_i, cfg_be_i, lb_fields);
			if (!lock_done_ff && cfg_be_i[1])
			begin
				nxt_genctrl[`RMP_LOCK_BIT] = cfg_wdata_i[`RMP_LOCK_BIT];
				nxt_lock_done = 1'b1;
			end
		end
		if (wr && cfg_addr_i == `RMP_TUNING_OFS && lb_ok)
			nxt_tuning = merge(tuning_ff, cfg_wdata_i, cfg_be_i, 32'h0007_ff8e);
		if (wr && cfg_addr_i == `RMP_PART_OFS)
		begin
			nxt_part = merge(part_ff, cfg_wdata_i, cfg_be_i, `RMP_PART_MASK & ~32'h1);
			if (lb_ok)
				nxt_part = merge(nxt_part, cfg_wdata_i, cfg_be_i, 32'h1);
		end
		if (wr && cfg_addr_i == `RMP_MSK_OFS)
			nxt_msk = merge(msk_ff, cfg_wdata_i, cfg_be_i, `RMP_ERR_MASK);
		if (wr && cfg_addr_i == `RMP_SEV_OFS)
			nxt_sev = merge(sev_ff, cfg_wdata_i, cfg_be_i, `RMP_ERR_MASK);
		// Hardware set wins over a same-cycle write-one clear
		set_vec = '0;
		set_vec[8:0] = err_event_i;
		set_vec[`RMP_MISC_BIT] = err_event_i[`RMP_MISC_BIT] || misc_evt;
		set_vec[`RMP_FAULT_BIT] = remap_fault_i;
		nxt_sts = sts_ff;
		if (wr && cfg_addr_i == `RMP_STS_OFS)
			nxt_sts = sts_ff & ~merge(32'h0, cfg_wdata_i, cfg_be_i, `RMP_ERR_MASK);
		nxt_sts = nxt_sts | set_vec;
		nxt_ack = cfg_valid_i;
		nxt_rdata = '0;
		if (cfg_valid_i && !cfg_write_i)
		begin
			unique case (cfg_addr_i)
				`RMP_GENCTRL_OFS: nxt_rdata = genctrl_ff;
				`RMP_TUNING_OFS: nxt_rdata = tuning_ff;
				`RMP_PART_OFS: nxt_rdata = part_ff;
				`RMP_STS_OFS: nxt_rdata = sts_ff;
				`RMP_MSK_OFS: nxt_rdata = msk_ff;
				`RMP_SEV_OFS: nxt_rdata = sev_ff;
				default: nxt_rdata = '0;
			endcase
		end
		nxt_bew = genctrl_ff[`RMP_LOCK_BIT] && cfg_trusted_i;
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			genctrl_ff <= `RMP_GENCTRL_RST;
			lock_done_ff <= 1'b0;
			tuning_ff <= `RMP_TUNING_RST;
			part_ff <= `RMP_PART_RST;
			msk_ff <= `RMP_MSK_RST;
			sev_ff <= `RMP_SEV_RST;
			sts_ff <= '0;
			rdata_ff <= '0;
			ack_ff <= 1'b0;
			bew_ff <= 1'b0;
		end
		else
		begin
			genctrl_ff <= nxt_genctrl;
			lock_done_ff <= nxt_lock_done;
			tuning_ff <= nxt_tuning;
			part_ff <= nxt_part;
			msk_ff <= nxt_msk;
			sev_ff <= nxt_sev;
			sts_ff <= nxt_sts;
			rdata_ff <= nxt_rdata;
			ack_ff <= nxt_ack;
			bew_ff <= nxt_bew;
		end
	end

	// Address limit checks
	logic [3:0] gpa_code;
	logic [6:0] hpa_w;
	logic [6:0] gpa_w;
	logic host_chk;
	logic guest_chk;
	logic host_over;
	logic guest_over;
	logic at_bad;
	logic abort_ff;
	logic nxt_abort;
	logic ur_ff;
	logic nxt_ur;

	always_comb
	begin
		hpa_w = `RMP_HPA_BASE + 7'(genctrl_ff[`RMP_HPA_MSB:`RMP_HPA_LSB]);
		// Reserved guest codes are treated as the widest legal code
		gpa_code = genctrl_ff[`RMP_GPA_MSB:`RMP_GPA_LSB];
		if (gpa_code > `RMP_GPA_MAX_CODE)
			gpa_code = `RMP_GPA_MAX_CODE;
		gpa_w = `RMP_GPA_BASE + 7'(gpa_code);
		host_chk = (translation_on_i && req_walk_i)
			|| req_passthru_i || req_at_i == RMP_AT_TRANSLATED;
		guest_chk = translation_on_i && req_noniso_i && !req_walk_i && !req_passthru_i
			&& req_at_i != RMP_AT_TRANSLATED;
		host_over = req_valid_i && host_chk && over_limit(req_addr_i, hpa_w);
		guest_over = req_valid_i && guest_chk && over_limit(req_addr_i, gpa_w);
		at_bad = req_valid_i && !translation_on_i && req_at_i != RMP_AT_UNTRANSLATED;
		misc_evt = at_bad || illegal_intr_region_i || host_over || guest_over;
		nxt_abort = host_over || guest_over;
		nxt_ur = guest_over;
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			abort_ff <= 1'b0;
			ur_ff <= 1'b0;
		end
		else
		begin
			abort_ff <= nxt_abort;
			ur_ff <= nxt_ur;
		end
	end

	// Error escalation; logging above is never masked
	logic fatal_ff;
	logic nxt_fatal;
	logic nonfatal_ff;
	logic nxt_nonfatal;
	rmp_err_vec_t ctl_view;
	rmp_err_vec_t live;
	logic fault_live;

	always_comb
	begin
		ctl_view = sts_to_ctl(sts_ff[8:0]);
		live = ctl_view & ~msk_ff[8:0];
		fault_live = sts_ff[`RMP_FAULT_BIT] && !msk_ff[`RMP_FAULT_BIT];
		nxt_fatal = |(live & sev_ff[8:0])
			|| (fault_live && sev_ff[`RMP_FAULT_BIT]);
		nxt_nonfatal = |(live & ~sev_ff[8:0])
			|| (fault_live && !sev_ff[`RMP_FAULT_BIT]);
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			fatal_ff <= 1'b0;
			nonfatal_ff <= 1'b0;
		end
		else
		begin
			fatal_ff <= nxt_fatal;
			nonfatal_ff <= nxt_nonfatal;
		end
	end

	// Translation-cache tuning
	logic [6:0] thr;
	logic retry_ff;
	logic nxt_retry;
	logic evict_ff;
	logic nxt_evict;
	logic ubit_ff;
	logic nxt_ubit;

	always_comb
	begin
		thr = tuning_ff[`RMP_THR_MSB:`RMP_THR_LSB];
		nxt_retry = prefetch_req_i && thr != 7'h00 && free_entries_i < thr;
		nxt_ubit = evict_valid_i && evict_leaf_i && evict_at_i == RMP_AT_UNTRANSLATED
			&& !tuning_ff[`RMP_IGN_UBIT_BIT];
		nxt_evict = 1'b0;
		if (evict_valid_i && evict_at_i == RMP_AT_XLATE_REQ)
		begin
			if (!evict_leaf_i)
				nxt_evict = tuning_ff[`RMP_EVICT_NL_BIT];
			else
				nxt_evict = !evict_ubit_i && !tuning_ff[`RMP_KEEP_LEAF_BIT];
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			retry_ff <= 1'b0;
			evict_ff <= 1'b0;
			ubit_ff <= 1'b0;
		end
		else
		begin
			retry_ff <= nxt_retry;
			evict_ff <= nxt_evict;
			ubit_ff <= nxt_ubit;
		end
	end

	rmp_lru_ager #(
		.CNT_W(12)
	) u_ager (
		.clk_i(clk_i),
		.rst_n_i(rst_n),
		.source_cycles_i(tuning_ff[`RMP_SRC_BIT]),
		.rate_i(tuning_ff[`RMP_RATE_MSB:`RMP_RATE_LSB]),
		.req_i(req_valid_i),
		.degrade_o(lru_degrade_o)
	);

	assign cfg_rdata_o = rdata_ff;
	assign cfg_ack_o = ack_ff;
	assign base_enable_writable_o = bew_ff;
	assign req_abort_o = abort_ff;
	assign req_ur_o = ur_ff;
	assign err_fatal_o = fatal_ff;
	assign err_nonfatal_o = nonfatal_ff;
	assign prefetch_retry_o = retry_ff;
	assign early_evict_o = evict_ff;
	assign leaf_ubit_used_o = ubit_ff;
	assign part_en_o = part_ff[`RMP_PART_EN_BIT];
	assign range_sel_bridge_o = part_ff[28:27];
	assign range_sel_upper24_o = part_ff[26:25];
	assign range_sel_upper23_o = part_ff[24:23];
	assign range_select_mgmt_engine_o = part_ff[14:13];
	assign range_select_copy_engine_o = part_ff[12:11];
	assign range_sel_intr_o = part_ff[10:9];
endmodule

// ---- verification/rmp_dma_source.sv ----
module rmp_dma_source
(
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic [63:0] addr_i,
	input wire logic [1:0] at_i,
	input wire logic pt_i,
	input wire logic walk_i,
	output logic valid_o,
	output logic [63:0] addr_o,
	output logic [1:0] at_o,
	output logic pt_o,
	output logic walk_o
);
	timeunit 1ns;
	timeprecision 1ns;

	initial
	begin
		valid_o = 1'h0;
		addr_o = '0;
		at_o = 2'h0;
		pt_o = 1'h0;
		walk_o = 1'h0;
	end

	// One-cycle request; idle fields flip so stale values never pass
	always @(posedge clk_i)
	begin
		valid_o <= go_i;
		addr_o <= go_i ? addr_i : ~addr_o;
		at_o <= go_i ? at_i : ~at_o;
		pt_o <= go_i ? pt_i : ~pt_o;
		walk_o <= go_i ? walk_i : ~walk_o;
	end
endmodule

// ---- verification/rmp_limits_errors_monitor.sv ----
module rmp_limits_errors_monitor
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic cfg_trusted_i,
	input wire logic base_enable_writable_o,
	input wire logic translation_on_i,
	input wire logic req_valid_i,
	input wire logic [1:0] req_at_i,
	input wire logic req_passthru_i,
	input wire logic req_walk_i,
	input wire logic req_abort_o,
	input wire logic req_ur_o,
	input wire logic [6:0] free_entries_i,
	input wire logic prefetch_req_i,
	input wire logic prefetch_retry_o,
	input wire logic lru_degrade_o,
	input wire logic evict_valid_i,
	input wire logic [1:0] evict_at_i,
	input wire logic evict_leaf_i,
	input wire logic evict_ubit_i,
	input wire logic early_evict_o,
	input wire logic leaf_ubit_used_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!resetn_i);

	ur_with_abort_a: assert property (req_ur_o |-> req_abort_o)
		else $error("ur without abort");
	guest_off_a: assert property (req_valid_i && !translation_on_i &&
		req_at_i == 2'h0 && !req_passthru_i |=> !req_abort_o && !req_ur_o)
		else $error("check while off");
	host_no_ur_a: assert property (req_valid_i && (req_passthru_i || req_walk_i ||
		req_at_i == 2'h2) |=> !req_ur_o)
		else $error("ur on host address");
	retry_cause_a: assert property (!prefetch_req_i || free_entries_i == 7'h7f
		|=> !prefetch_retry_o)
		else $error("retry without cause");
	degrade_pulse_a: assert property (lru_degrade_o |=> !lru_degrade_o [*8])
		else $error("degrade too soon");
	leaf_used_a: assert property (evict_valid_i && evict_leaf_i && evict_ubit_i
		|=> !early_evict_o)
		else $error("used leaf marked");
	ubit_at00_a: assert property (evict_valid_i && evict_at_i != 2'h0
		|=> !leaf_ubit_used_o)
		else $error("u bit policy off at00");
	writable_trust_a: assert property (base_enable_writable_o |-> $past(cfg_trusted_i))
		else $error("writable untrusted");
endmodule

bind rmp_limits_errors rmp_limits_errors_monitor rmp_limits_errors_monitor_inst (.clk_i,
	.resetn_i, .cfg_trusted_i, .base_enable_writable_o, .translation_on_i, .req_valid_i,
	.req_at_i, .req_passthru_i, .req_walk_i, .req_abort_o, .req_ur_o, .free_entries_i,
	.prefetch_req_i, .prefetch_retry_o, .lru_degrade_o, .evict_valid_i, .evict_at_i,
	.evict_leaf_i, .evict_ubit_i, .early_evict_o, .leaf_ubit_used_o);

// ---- verification/rmp_limits_errors_bench.sv ----
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin err_total++; \
	$display("MISMATCH %s exp %h got %h", n, e, a); end end

module rmp_limits_errors_bench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk_i = 0, resetn_i = 0, cfg_valid_i = 0, cfg_write_i = 0, cfg_trusted_i = 0;
	logic translation_on_i = 0, req_noniso_i = 1, illegal_intr_region_i = 0, remap_fault_i = 0;
	logic prefetch_req_i = 0, evict_valid_i = 0, evict_leaf_i = 0, evict_ubit_i = 0, go = 0;
	logic pt = 0, wk = 0;
	logic [1:0] evict_at_i = '0, gat = '0;
	logic [3:0] cfg_be_i = 4'hf;
	logic [6:0] free_entries_i = 7'h7f;
	logic [8:0] err_event_i = '0;
	logic [11:0] cfg_addr_i = '0;
	logic [31:0] cfg_wdata_i = '0, rd;
	logic [63:0] ga = '0;
	int err_total = 0, num_checks = 0, cyc = 0, dgn = 0;
	wire logic req_valid_i, req_passthru_i, req_walk_i, cfg_ack_o, base_enable_writable_o;
	wire logic req_abort_o, req_ur_o, err_fatal_o, err_nonfatal_o, prefetch_retry_o;
	wire logic lru_degrade_o, early_evict_o, leaf_ubit_used_o, part_en_o;
	wire logic [1:0] req_at_i;
	wire logic [11:0] rs;
	wire logic [31:0] cfg_rdata_o;
	wire logic [63:0] req_addr_i;

	rmp_dma_source rmp_dma_source_inst (.clk_i, .go_i(go), .addr_i(ga), .at_i(gat), .pt_i(pt),
		.walk_i(wk), .valid_o(req_valid_i), .addr_o(req_addr_i), .at_o(req_at_i),
		.pt_o(req_passthru_i), .walk_o(req_walk_i));

	rmp_limits_errors rmp_limits_errors_inst (.clk_i, .resetn_i, .cfg_valid_i, .cfg_write_i,
		.cfg_addr_i, .cfg_be_i, .cfg_wdata_i, .cfg_trusted_i, .cfg_rdata_o, .cfg_ack_o,
		.base_enable_writable_o, .translation_on_i, .req_valid_i, .req_addr_i, .req_at_i,
		.req_passthru_i, .req_walk_i, .req_noniso_i, .illegal_intr_region_i, .req_abort_o,
		.req_ur_o, .err_event_i, .remap_fault_i, .err_fatal_o, .err_nonfatal_o,
		.free_entries_i, .prefetch_req_i, .prefetch_retry_o, .lru_degrade_o, .evict_valid_i,
		.evict_at_i, .evict_leaf_i, .evict_ubit_i, .early_evict_o, .leaf_ubit_used_o,
		.part_en_o, .range_sel_bridge_o(rs[11:10]), .range_sel_upper24_o(rs[9:8]),
		.range_sel_upper23_o(rs[7:6]), .range_select_mgmt_engine_o(rs[5:4]),
		.range_select_copy_engine_o(rs[3:2]), .range_sel_intr_o(rs[1:0]));

	always #20 clk_i = ~clk_i;

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	// Counted between edges so scenario tasks never race the count
	always @(negedge clk_i)
	begin
		cyc++;
		if (lru_degrade_o === 1'h1)
			dgn++;
		if (cyc == 20000)
		begin
			err_total++;
			give_verdict();
		end
	end

	task automatic cfg(input logic wr, input logic [11:0] ad, input logic [31:0] d);
		@(posedge clk_i) #1 cfg_valid_i = 1;
		cfg_write_i = wr;
		cfg_addr_i = ad;
		cfg_wdata_i = d;
		@(posedge clk_i) #1 cfg_valid_i = 0;
		rd = cfg_rdata_o;
		`CHK("ack", 1'h1, cfg_ack_o)
	endtask

	task automatic req(input logic [63:0] ad, input logic [1:0] t, input logic p, input logic k,
		input logic ea, input logic eu);
		@(posedge clk_i) #1 go = 1;
		ga = ad;
		gat = t;
		pt = p;
		wk = k;
		@(posedge clk_i) #1 go = 0;
		@(posedge clk_i) #1 `CHK("abort", ea, req_abort_o)
		`CHK("ur", eu, req_ur_o)
	endtask

	task automatic pulse(input logic [8:0] e, input logic f);
		@(posedge clk_i) #1 err_event_i = e;
		remap_fault_i = f;
		@(posedge clk_i) #1 err_event_i = '0;
		remap_fault_i = 0;
	endtask

	task automatic pref(input logic [6:0] f, input logic e);
		@(posedge clk_i) #1 prefetch_req_i = 1;
		free_entries_i = f;
		@(posedge clk_i) #1 prefetch_req_i = 0;
		`CHK("retry", e, prefetch_retry_o)
	endtask

	task automatic evict(input logic [1:0] t, input logic l, input logic u, input logic ee,
		input logic lu);
		@(posedge clk_i) #1 evict_valid_i = 1;
		evict_at_i = t;
		evict_leaf_i = l;
		evict_ubit_i = u;
		@(posedge clk_i) #1 evict_valid_i = 0;
		`CHK("early evict", ee, early_evict_o)
		`CHK("u bit used", lu, leaf_ubit_used_o)
	endtask

	task automatic t_reset();
		logic [11:0] ofs [7] = '{12'h184, 12'h18c, 12'h194, 12'h1a8, 12'h1ac, 12'h1b0, 12'h188};
		logic [31:0] ex [7] = '{32'ha8, 32'h4380, 32'h0, 32'h0, 32'h80000000, 32'h1bf, 32'h0};
		for (int i = 0; i < 7; i++)
		begin
			cfg(0, ofs[i], 32'h0);
			`CHK("reset value", ex[i], rd)
		end
	endtask

	task automatic t_guest();
		translation_on_i = 1;
		req(64'h1 << 48, 2'h0, 0, 0, 1, 1);
		req((64'h1 << 48) - 1, 2'h0, 0, 0, 0, 0);
		cfg(1, 12'h184, 32'ha0);
		req(64'h1 << 40, 2'h0, 0, 0, 1, 1);
		req(64'h1 << 40, 2'h0, 1, 0, 0, 0);
		req_noniso_i = 0;
		req(64'h1 << 40, 2'h0, 0, 0, 0, 0);
		req_noniso_i = 1;
		cfg(0, 12'h1a8, 32'h0);
		`CHK("limit misc", 32'h80, rd)
		`CHK("misc fatal", 1'h1, err_fatal_o)
		cfg(1, 12'h1a8, 32'h80);
		translation_on_i = 0;
		req(64'h1 << 40, 2'h0, 0, 0, 0, 0);
		cfg(0, 12'h1a8, 32'h0);
		`CHK("status cleared", 32'h0, rd)
		req(64'h0, 2'h1, 0, 0, 0, 0);
		cfg(0, 12'h1a8, 32'h0);
		`CHK("at while off", 32'h80, rd)
		cfg(1, 12'h1a8, 32'h80);
		@(posedge clk_i) #1 illegal_intr_region_i = 1;
		@(posedge clk_i) #1 illegal_intr_region_i = 0;
		cfg(0, 12'h1a8, 32'h0);
		`CHK("interrupt region", 32'h80, rd)
		cfg(1, 12'h1a8, 32'h80);
	endtask

	task automatic t_host();
		translation_on_i = 1;
		req(64'h1 << 46, 2'h2, 0, 0, 1, 0);
		req((64'h1 << 46) - 1, 2'h0, 1, 0, 0, 0);
		req(64'h1 << 46, 2'h0, 0, 1, 1, 0);
		cfg(1, 12'h184, 32'h0);
		req(64'h1 << 36, 2'h0, 1, 0, 1, 0);
		req((64'h1 << 36) - 1, 2'h2, 0, 0, 0, 0);
		cfg(1, 12'h1a8, 32'h80);
	endtask

	task automatic t_err();
		for (int i = 0; i < 9; i++)
		begin
			pulse(9'h1 << i, 0);
			cfg(0, 12'h1a8, 32'h0);
			`CHK("error status", 32'h1 << i, rd)
			cfg(1, 12'h1a8, 32'h1 << i);
		end
		pulse(9'h4, 0);
		cfg(1, 12'h1b0, 32'h1bd);
		#80 `CHK("l1 severity", 2'h1, {err_fatal_o, err_nonfatal_o})
		cfg(1, 12'h1ac, 32'h80000002);
		#80 `CHK("l1 masked", 2'h0, {err_fatal_o, err_nonfatal_o})
		pulse(9'h0, 1);
		cfg(0, 12'h1a8, 32'h0);
		`CHK("masked logged", 32'h80000004, rd)
		`CHK("fault masked", 2'h0, {err_fatal_o, err_nonfatal_o})
		cfg(1, 12'h1ac, 32'h2);
		#80 `CHK("fault nonfatal", 2'h1, {err_fatal_o, err_nonfatal_o})
		cfg(1, 12'h1b0, 32'h800001bd);
		#80 `CHK("fault fatal", 2'h2, {err_fatal_o, err_nonfatal_o})
		cfg(1, 12'h1a8, 32'hffffffff);
		cfg(1, 12'h1ac, 32'h80000000);
		cfg(1, 12'h1b0, 32'h1bf);
	endtask

	task automatic t_lru();
		int d;
		cfg(1, 12'h18c, 32'h880);
		d = dgn;
		for (int i = 0; i < 4200 && d == dgn; i++)
			@(posedge clk_i);
		d = dgn;
		repeat (255) @(posedge clk_i);
		`CHK("cycle ageing", d, dgn)
		repeat (2) @(posedge clk_i);
		`CHK("cycle ageing", d + 1, dgn)
		cfg(1, 12'h18c, 32'h80);
		d = dgn;
		for (int i = 0; i < 300 && d == dgn; i++)
		begin
			req(64'h0, 2'h0, 0, 0, 0, 0);
			repeat (2) @(posedge clk_i);
		end
		d = dgn;
		repeat (15) req(64'h0, 2'h0, 0, 0, 0, 0);
		#120 `CHK("request ageing", d, dgn)
		req(64'h0, 2'h0, 0, 0, 0, 0);
		#120 `CHK("request ageing", d + 1, dgn)
	endtask

	initial
	begin
		repeat (5) @(posedge clk_i);
		#1 resetn_i = 1;
		repeat (3) @(posedge clk_i);
		t_reset();
		// Limit writes keep off byte 1 so the write-once lock stays free
		cfg_be_i = 4'h1;
		t_guest();
		t_host();
		cfg_be_i = 4'hf;
		t_err();
		pref(7'h3, 1);
		pref(7'h4, 0);
		cfg(1, 12'h18c, 32'h380);
		pref(7'h0, 0);
		evict(2'h1, 0, 0, 0, 0);
		evict(2'h1, 1, 0, 1, 0);
		evict(2'h0, 1, 1, 0, 1);
		cfg(1, 12'h18c, 32'h38e);
		evict(2'h1, 0, 0, 1, 0);
		evict(2'h1, 1, 0, 0, 0);
		evict(2'h0, 1, 1, 0, 0);
		t_lru();
		cfg(1, 12'h194, 32'hffffffff);
		cfg(0, 12'h194, 32'h0);
		`CHK("partition", 32'h1f807e01, rd)
		`CHK("partition out", 13'h1fff, {part_en_o, rs})
		cfg(1, 12'h184, 32'h8000);
		cfg(1, 12'h184, 32'ha8);
		cfg(0, 12'h184, 32'h0);
		`CHK("locked fields", 32'h8000, rd)
		`CHK("not writable", 1'h0, base_enable_writable_o)
		cfg_trusted_i = 1;
		cfg(1, 12'h184, 32'ha8);
		cfg(0, 12'h184, 32'h0);
		`CHK("trusted write", 32'h80a8, rd)
		`CHK("writable", 1'h1, base_enable_writable_o)
		cfg_trusted_i = 0;
		cfg(1, 12'h194, 32'h0);
		cfg(0, 12'h194, 32'h0);
		`CHK("partition lock", 32'h1, rd)
		give_verdict();
	end
endmodule
